// ### hw/ccm_pkg.sv
// constants and carrier types for the counter array capture/compare channel
// Function
// (RQ1) wide PWM bit picks 8-11 or 16-bit
// (RQ2) comparator works only while its enable set
// (RQ3) rising capture enable captures on positive edges
// (RQ4) falling capture enable captures on negative edges
// (RQ5) match enable sets event flag on equality
// (RQ6) toggle enable inverts pin on each equality
// (RQ7) PWM enable drives PWM wave on pin
// (RQ8) toggle plus PWM means frequency output mode
// (RQ9) interrupt enable bit masks event flag request
// (RQ10) mode register fully read/write, resets zero
// (RQ11) low byte write clears comparator enable
// (RQ12) select bit steers low byte to reload
// (RQ13) capture copies counter and sets flag
package ccm_pkg;
	// register addresses on the plain port
	localparam logic [7:0] ADDR_MODE = 8'hDC; // channel2_capture_compare_mode
	localparam logic [7:0] ADDR_CAP_LOW = 8'hE9; // channel1_capture_low_byte
	localparam logic [7:0] ADDR_CAP_HIGH = 8'hF0; // capture/compare high byte
	localparam logic [7:0] ADDR_CONFIG = 8'hF1; // reload select and PWM width
	localparam logic [7:0] ADDR_STATUS = 8'hF2; // sticky event flag, write one to clear
	localparam logic [7:0] ADDR_MASK = 8'hF3; // interrupt mask, same layout
	// field positions
	localparam int CFG_AUTO_RELOAD_SELECT_BIT = 0; // auto_reload_select
	localparam int CFG_WIDTH_LSB = 1; // extra PWM bits above 8 (0..3)
	localparam int STAT_FLAG_BIT = 0; // channel2_event_flag
	// reset values
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [15:0] CC_RST = 16'h0000;
	// narrow PWM base width
	localparam int PWM_BASE_W = 8;

	// channel mode register layout
	typedef struct packed {
		logic wide_pwm_select; // bit 7
		logic comparator_function_enable; // bit 6
		logic rising_capture_enable; // bit 5
		logic falling_capture_enable; // bit 4
		logic match_enable; // bit 3
		logic toggle_enable; // bit 2
		logic pwm_enable; // bit 1
		logic flag_interrupt_enable; // bit 0
	} ccm_mode_s;

	// register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ccm_bus_s;
endpackage

// ### hw/ccm_channel.sv
// capture/compare channel: mode control, capture, match, toggle, PWM, frequency output
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
// one channel of the counter array: the mode register picks capture, match,
// toggle, PWM or frequency output. The counter arrives on this clock already,
// so only the channel pin is synchronised. The 16-bit capture value is two
// independent bytes with no latch between them. A low byte write also stops
// the comparator, so software writes the mode register after the compare
// bytes to start the channel again.
module ccm_channel #(
	parameter int CNT_W = 16
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire ccm_pkg::ccm_bus_s bus,
	output logic [7:0] rdata,
	input wire logic [CNT_W-1:0] cnt,
	input wire logic pin_i,
	output logic pin_o,
	output logic pin_oe,
	output logic irq
);
	import ccm_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// state
	ccm_mode_s mode_q, mode_d; // channel mode register
	logic [CNT_W-1:0] cc_q, cc_d; // capture/compare value
	logic [7:0] reload_q, reload_d; // auto-reload low byte
	logic [7:0] cfg_q, cfg_d; // reload select and width
	logic flag_q, flag_d; // sticky event flag
	logic mask_q, mask_d; // interrupt mask
	logic pin_q, pin_d; // driven pin level
	logic [7:0] rdata_q, rdata_d; // read data, one cycle after strobe
	logic [CNT_W-1:0] cnt_prev_q; // counter last cycle
	logic sync1_q, sync2_q, sync3_q; // pin synchroniser and edge history
	logic sync1_d, sync2_d, sync3_d; // synchroniser next values
	logic [CNT_W-1:0] cnt_prev_d; // counter history next value

	// decoded strokes
	logic wr_mode, wr_low, wr_high, wr_cfg, wr_stat, wr_mask;
	logic step; // counter moved this cycle
	logic match_evt; // full-width equality on a fresh count
	logic low_evt; // low byte equality on a fresh count
	logic rise, fall; // synchronised pin edges
	logic cap_evt; // qualifying capture edge
	logic auto_reload_select; // low byte reaches the reload byte
	logic [1:0] wsel; // extra narrow PWM bits
	logic [CNT_W-1:0] pmask; // narrow PWM count mask
	logic wrap; // narrow PWM period restart
	logic pwm_lvl; // PWM comparison level
	logic freq_mode; // toggle and PWM together

	////////////////////////////////////////////////////////////////////////
	// decode and events
	always_comb begin
		wr_mode = bus.wr && (bus.addr == ADDR_MODE);
		wr_low = bus.wr && (bus.addr == ADDR_CAP_LOW);
		wr_high = bus.wr && (bus.addr == ADDR_CAP_HIGH);
		wr_cfg = bus.wr && (bus.addr == ADDR_CONFIG);
		wr_stat = bus.wr && (bus.addr == ADDR_STATUS);
		wr_mask = bus.wr && (bus.addr == ADDR_MASK);
		// config fields
		auto_reload_select = cfg_q[CFG_AUTO_RELOAD_SELECT_BIT];
		wsel = cfg_q[CFG_WIDTH_LSB +: 2];
		// a stalled counter must not repeat a match, so events need a fresh count
		step = (cnt != cnt_prev_q);
		// match and low byte events only count while the comparator is on; captures do not need it
		match_evt = mode_q.comparator_function_enable && step && (cnt == cc_q); // RQ2
		low_evt = mode_q.comparator_function_enable && step && (cnt[7:0] == cc_q[7:0]); // RQ2
		// edges look at the second and third stages only
		rise = sync2_q && !sync3_q;
		fall = !sync2_q && sync3_q;
		// either edge may qualify; both bits set capture on every change
		cap_evt = (rise && mode_q.rising_capture_enable) // RQ3
			|| (fall && mode_q.falling_capture_enable); // RQ4
		// narrow period mask: eight bits plus the extra width field
		pmask = CNT_W'((32'h1 << (PWM_BASE_W + 32'(wsel))) - 32'h1);
		// the narrow period restarts when the masked count returns to zero
		wrap = step && ((cnt & pmask) == '0);
		freq_mode = mode_q.toggle_enable && mode_q.pwm_enable; // RQ8
		// pin high while the count is below the compare value
		if (mode_q.wide_pwm_select) begin
			pwm_lvl = (cnt < cc_q); // RQ1
		end else begin
			pwm_lvl = ((cnt & pmask) < (cc_q & pmask)); // RQ1
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register next values
	always_comb begin
		mode_d = mode_q;
		cfg_d = cfg_q;
		mask_d = mask_q;
		reload_d = reload_q;
		cc_d = cc_q;
		flag_d = flag_q;
		// software writes
		// a mode write replaces all eight bits
		if (wr_mode) begin
			mode_d = ccm_mode_s'(bus.wdata); // RQ10
		end
		// config holds the reload select and the narrow width
		if (wr_cfg) begin
			cfg_d = bus.wdata;
		end
		// only the flag bit of the mask is stored
		if (wr_mask) begin
			mask_d = bus.wdata[STAT_FLAG_BIT];
		end
		if (wr_low) begin
			// a low byte write stops the comparator
			mode_d.comparator_function_enable = 1'b0; // RQ11
			if (auto_reload_select) begin
				reload_d = bus.wdata; // RQ12
			end else begin
				cc_d[7:0] = bus.wdata; // RQ12
			end
		end
		// the high byte is never steered; it reaches the compare value unless a capture lands in the same cycle
		if (wr_high) begin
			cc_d[15:8] = bus.wdata;
		end
		// frequency output steps the next edge by the high byte
		if (freq_mode && low_evt) begin
			cc_d[7:0] = 8'(cc_q[7:0] + cc_q[15:8]); // RQ8
		end else if (mode_q.comparator_function_enable && mode_q.pwm_enable
			&& !mode_q.wide_pwm_select && wsel != 2'h0 && wrap) begin
			// narrow PWM above 8 bits reloads at the period start
			cc_d[7:0] = reload_q;
		end
		// a capture wins over a software byte write
		if (cap_evt) begin
			cc_d = cnt; // RQ13
		end
		// write one clears, a new event in the same cycle wins
		if (wr_stat && bus.wdata[STAT_FLAG_BIT]) begin
			flag_d = 1'b0;
		end
		if (cap_evt) begin
			flag_d = 1'b1; // RQ13
		end
		if (match_evt && mode_q.match_enable) begin
			flag_d = 1'b1; // RQ5
		end
	end

	// register the channel state; reset clears every byte
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_q <= ccm_mode_s'(MODE_RST);
			cfg_q <= BYTE_RST;
			mask_q <= 1'b0;
			reload_q <= BYTE_RST;
			cc_q <= CNT_W'(CC_RST);
			flag_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			cfg_q <= cfg_d;
			mask_q <= mask_d;
			reload_q <= reload_d;
			cc_q <= cc_d;
			flag_q <= flag_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin output next value
	always_comb begin
		pin_d = pin_q;
		// priority: comparator off, frequency, PWM, then plain toggle
		if (!mode_q.comparator_function_enable) begin
			pin_d = pin_q; // RQ2
		end else if (freq_mode) begin
			if (low_evt) begin
				pin_d = !pin_q; // RQ8
			end
		end else if (mode_q.pwm_enable) begin
			pin_d = pwm_lvl; // RQ7
		end else if (mode_q.toggle_enable) begin
			if (match_evt) begin
				pin_d = !pin_q; // RQ6
			end
		end
	end

	// register the pin level so the pin never glitches
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_q <= 1'b0;
		end else begin
			pin_q <= pin_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin synchroniser and counter history
	// the synchroniser shifts one stage per clock; history follows the counter
	always_comb begin
		sync1_d = pin_i;
		sync2_d = sync1_q;
		sync3_d = sync2_q;
		cnt_prev_d = cnt;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
			cnt_prev_q <= '0;
		end else begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
			sync3_q <= sync3_d;
			cnt_prev_q <= cnt_prev_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read port: data stand only in the cycle after the strobe
	always_comb begin
		rdata_d = 8'h00;
		if (bus.rd) begin
			// unmapped addresses read as zero
			case (bus.addr)
				ADDR_MODE: rdata_d = mode_q; // RQ10
				ADDR_CAP_LOW: rdata_d = auto_reload_select ? reload_q : cc_q[7:0]; // RQ12
				ADDR_CAP_HIGH: rdata_d = cc_q[15:8];
				ADDR_CONFIG: rdata_d = cfg_q;
				ADDR_STATUS: rdata_d = {7'h00, flag_q};
				ADDR_MASK: rdata_d = {7'h00, mask_q};
				default: rdata_d = 8'h00;
			endcase
		end
	end

	// register the read data; it drops back to zero after one cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// outputs
	assign rdata = rdata_q;
	assign pin_o = pin_q;
	// drive the pin only in an output mode
	assign pin_oe = mode_q.comparator_function_enable
		&& (mode_q.toggle_enable || mode_q.pwm_enable); // RQ2
	// irq follows the registered flag, so it rises one clock after the event
	assign irq = flag_q && mode_q.flag_interrupt_enable && mask_q; // RQ9

	////////////////////////////////////////////////////////////////////////
	// assertions
	// checks on the registered state; all are cut by the asynchronous reset
	// a consequent one clock on looks at the values the edge has just loaded
	a_oe_needs_comp: assert property (@(posedge clk) disable iff (!arst_n) // RQ2
		pin_oe |-> mode_q.comparator_function_enable)
		else $error("pin driven with comparator off");

	a_rise_capture: assert property (@(posedge clk) disable iff (!arst_n) // RQ3
		(rise && mode_q.rising_capture_enable) |=> (flag_q && cc_q == $past(cnt)))
		else $error("rising edge not captured");

	a_fall_capture: assert property (@(posedge clk) disable iff (!arst_n) // RQ4
		(fall && mode_q.falling_capture_enable) |=> (flag_q && cc_q == $past(cnt)))
		else $error("falling edge not captured");

	a_match_flag: assert property (@(posedge clk) disable iff (!arst_n) // RQ5
		(mode_q.comparator_function_enable && mode_q.match_enable && step
		&& cnt == cc_q) |=> flag_q)
		else $error("match did not set flag");

	a_toggle_pin: assert property (@(posedge clk) disable iff (!arst_n) // RQ6
		(match_evt && mode_q.toggle_enable && !mode_q.pwm_enable)
		|=> (pin_o != $past(pin_o)))
		else $error("match did not toggle pin");

	a_pwm_wide: assert property (@(posedge clk) disable iff (!arst_n) // RQ7
		(mode_q.comparator_function_enable && mode_q.pwm_enable
		&& !mode_q.toggle_enable && mode_q.wide_pwm_select)
		|=> (pin_o == ($past(cnt) < $past(cc_q)))) // RQ1
		else $error("wide PWM level wrong");

	a_freq_toggle: assert property (@(posedge clk) disable iff (!arst_n) // RQ8
		(freq_mode && low_evt && !cap_evt && !wr_low)
		|=> (pin_o != $past(pin_o))
		&& cc_q[7:0] == 8'($past(cc_q[7:0]) + $past(cc_q[15:8])))
		else $error("frequency output step wrong");

	a_irq_masked: assert property (@(posedge clk) disable iff (!arst_n) // RQ9
		!mode_q.flag_interrupt_enable |-> !irq)
		else $error("interrupt raised while masked");

	a_mode_write: assert property (@(posedge clk) disable iff (!arst_n) // RQ10
		wr_mode |=> mode_q == $past(bus.wdata))
		else $error("mode register write lost");

	a_mode_read: assert property (@(posedge clk) disable iff (!arst_n) // RQ10
		(bus.rd && bus.addr == ADDR_MODE) |=> rdata == $past(mode_q))
		else $error("mode register read wrong");

	a_rdata_idle: assert property (@(posedge clk) disable iff (!arst_n) // RQ10
		!bus.rd |=> rdata == 8'h00)
		else $error("read data outside the read cycle");

	a_low_clears: assert property (@(posedge clk) disable iff (!arst_n) // RQ11
		wr_low |=> !mode_q.comparator_function_enable)
		else $error("low write kept comparator on");

	a_reload_sel: assert property (@(posedge clk) disable iff (!arst_n) // RQ12
		(wr_low && auto_reload_select && !wr_cfg) |=> reload_q == $past(bus.wdata))
		else $error("reload byte not written");

	a_irq_mask_reg: assert property (@(posedge clk) disable iff (!arst_n) // RQ9
		!mask_q |-> !irq)
		else $error("interrupt raised while mask register clear");

	a_pin_hold_off: assert property (@(posedge clk) disable iff (!arst_n) // RQ2
		!mode_q.comparator_function_enable |=> pin_o == $past(pin_o))
		else $error("pin moved with comparator off");

	a_flag_sticky: assert property (@(posedge clk) disable iff (!arst_n) // RQ13
		(flag_q && !(wr_stat && bus.wdata[STAT_FLAG_BIT])) |=> flag_q)
		else $error("event flag lost without a clear");

	a_narrow_reload: assert property (@(posedge clk) disable iff (!arst_n) // RQ12
		(mode_q.comparator_function_enable && mode_q.pwm_enable && !mode_q.toggle_enable
		&& !mode_q.wide_pwm_select && wsel != 2'h0 && wrap && !cap_evt)
		|=> cc_q[7:0] == $past(reload_q))
		else $error("narrow PWM reload missed");

	// covers for capture, toggle, frequency, flag race and narrow reload
	c_capture: cover property (@(posedge clk) disable iff (!arst_n) cap_evt ##1 irq);
	c_toggle: cover property (@(posedge clk) disable iff (!arst_n)
		match_evt && mode_q.toggle_enable);
	c_freq: cover property (@(posedge clk) disable iff (!arst_n) freq_mode && low_evt);
	c_flag_race: cover property (@(posedge clk) disable iff (!arst_n)
		wr_stat && bus.wdata[0] && match_evt && mode_q.match_enable);
	c_narrow_reload: cover property (@(posedge clk) disable iff (!arst_n)
		mode_q.pwm_enable && !mode_q.wide_pwm_select && wsel != 2'h0 && wrap);
endmodule

// ### tb/ccm_pin_partner.sv
// partner model: external logic facing the channel pin
`timescale 1ns/10ps
module ccm_pin_partner (
	input wire logic pin_o,
	input wire logic pin_oe,
	input wire logic drive_lvl,
	output logic pin_i
);
	// the device drive wins while enabled, otherwise the outside level
	assign pin_i = pin_oe ? pin_o : drive_lvl;
endmodule

// ### tb/ccm_channel_test.sv
// self-checking bench for the capture/compare channel
`timescale 1ns/10ps
module ccm_channel_test;
	import ccm_pkg::*;
	typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} ccm_row_s;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	ccm_bus_s bus = '0;
	logic [15:0] cnt = 16'h0000;
	logic lvl = 1'b0; // outside pin level
	logic [7:0] rdata;
	logic pin_o;
	logic pin_oe;
	logic irq;
	logic pin_i;
	logic p; // remembered pin level
	int n_mismatch = 0;
	int tests_run = 0;
	// register rows: address, write data, expected readback
	ccm_row_s rows [8] = '{'{8'hDC, 8'hA5, 8'hA5}, '{8'hDC, 8'h5A, 8'h5A},
		'{8'hDC, 8'hFF, 8'hFF}, '{8'h10, 8'hFF, 8'h00}, '{8'hF3, 8'hFF, 8'h01},
		'{8'hF1, 8'h0E, 8'h0E}, '{8'hF1, 8'h00, 8'h00}, '{8'hDC, 8'h00, 8'h00}};

	ccm_channel dut_u (.clk(clk), .arst_n(arst_n), .bus(bus), .rdata(rdata), .cnt(cnt),
		.pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .irq(irq));
	ccm_pin_partner far_u (.pin_o(pin_o), .pin_oe(pin_oe), .drive_lvl(lvl), .pin_i(pin_i));

	// 40 MHz clock
	initial forever #12.5 clk = ~clk;

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// wait n edges, then let their updates land
	task automatic w(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string what);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1;
		chk(what, {8'h00, rdata}, {8'h00, e});
	endtask
	task automatic step(input logic [15:0] c);
		@(posedge clk);
		cnt <= c;
	endtask
	// set a mode, move the counter and the pin, let the capture land
	task automatic cap(input logic [7:0] m, input logic l, input logic [15:0] c);
		wr(ADDR_MODE, m);
		step(c);
		lvl <= l;
		w(6);
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// watchdog against a hang
	initial begin
		#500000;
		n_mismatch++;
		stop_test;
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		w(1);
		chk("irq rst", irq, 16'h0);
		chk("oe rst", pin_oe, 16'h0);
		rdchk(ADDR_MODE, MODE_RST, "mode rst");
		w(1);
		chk("rdata drop", rdata, 16'h0);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rdchk(rows[i].a, rows[i].e, "row");
		end
		$display("test registers done");
		// edge capture, each direction on and off
		cap(8'h20, 1'b1, 16'h1234);
		rdchk(ADDR_CAP_LOW, 8'h34, "cap lo");
		rdchk(ADDR_CAP_HIGH, 8'h12, "cap hi");
		rdchk(ADDR_STATUS, 8'h01, "cap flag");
		cap(8'h20, 1'b0, 16'h2222);
		rdchk(ADDR_CAP_LOW, 8'h34, "fall off");
		cap(8'h10, 1'b1, 16'h5678);
		rdchk(ADDR_CAP_LOW, 8'h34, "rise off");
		cap(8'h10, 1'b0, 16'h5678);
		rdchk(ADDR_CAP_LOW, 8'h78, "fall lo");
		wr(ADDR_STATUS, 8'h01);
		rdchk(ADDR_STATUS, 8'h00, "flag clr");
		$display("test capture done");
		// match flag and interrupt masking
		wr(ADDR_CAP_LOW, 8'h10);
		wr(ADDR_CAP_HIGH, 8'h00);
		wr(ADDR_MASK, 8'h01);
		wr(ADDR_MODE, 8'h49);
		step(16'h000F);
		step(16'h0010);
		w(3);
		chk("irq match", irq, 16'h1);
		rdchk(ADDR_STATUS, 8'h01, "match flag");
		wr(ADDR_STATUS, 8'h01);
		w(2);
		chk("irq clr", irq, 16'h0);
		wr(ADDR_MODE, 8'h48);
		step(16'h000F);
		step(16'h0010);
		w(3);
		chk("irq masked", irq, 16'h0);
		wr(ADDR_MODE, 8'h49);
		w(2);
		chk("irq unmask", irq, 16'h1);
		wr(ADDR_MASK, 8'h00);
		w(1);
		chk("irq mask reg", irq, 16'h0);
		wr(ADDR_STATUS, 8'h01);
		$display("test match done");
		// toggle, then comparator dropped by a low byte write
		wr(ADDR_MODE, 8'h44);
		w(1);
		chk("oe tog", pin_oe, 16'h1);
		p = pin_o;
		step(16'h000F);
		step(16'h0010);
		w(2);
		chk("tog", pin_o, !p);
		step(16'h0011);
		step(16'h0010);
		w(2);
		chk("tog back", pin_o, p);
		rdchk(ADDR_STATUS, 8'h00, "no match");
		wr(ADDR_CAP_LOW, 8'h10);
		rdchk(ADDR_MODE, 8'h04, "cmp clr");
		chk("oe off", pin_oe, 16'h0);
		step(16'h000F);
		step(16'h0010);
		w(2);
		chk("cmp off", pin_o, p);
		$display("test toggle done");
		// wide against narrow PWM on the same compare value
		wr(ADDR_MODE, 8'hC2);
		step(16'h0105);
		w(2);
		chk("pwm wide", pin_o, 16'h0);
		wr(ADDR_MODE, 8'h42);
		step(16'h0106);
		w(2);
		chk("pwm narrow", pin_o, 16'h1);
		step(16'h0120);
		w(2);
		chk("pwm low", pin_o, 16'h0);
		wr(ADDR_MODE, 8'hC2);
		step(16'h0005);
		w(2);
		chk("pwm high", pin_o, 16'h1);
		// frequency output steps the compare low byte
		wr(ADDR_CAP_HIGH, 8'h03);
		wr(ADDR_MODE, 8'h46);
		w(1);
		p = pin_o;
		step(16'h0210);
		w(2);
		chk("freq pin", pin_o, !p);
		rdchk(ADDR_CAP_LOW, 8'h13, "freq step");
		$display("test pwm done");
		// low byte address steered to the reload byte
		wr(ADDR_CONFIG, 8'h01);
		wr(ADDR_CAP_LOW, 8'h77);
		wr(ADDR_CONFIG, 8'h00);
		rdchk(ADDR_CAP_LOW, 8'h13, "cap kept");
		wr(ADDR_CONFIG, 8'h01);
		rdchk(ADDR_CAP_LOW, 8'h77, "reload");
		// 9-bit PWM: reload at the period start, level on nine bits
		wr(ADDR_CONFIG, 8'h03);
		wr(ADDR_CAP_LOW, 8'h55);
		wr(ADDR_MODE, 8'h42);
		step(16'h0200);
		step(16'h0260);
		w(2);
		chk("pwm 9bit", pin_o, 16'h1);
		wr(ADDR_CONFIG, 8'h02);
		rdchk(ADDR_CAP_LOW, 8'h55, "reload wrap");
		$display("test reload done");
		// mid-run reset with the pin driven: outputs drop at once
		@(posedge clk);
		arst_n <= 1'b0;
		w(1);
		chk("oe in rst", pin_oe, 16'h0);
		chk("pin in rst", pin_o, 16'h0);
		chk("irq in rst", irq, 16'h0);
		@(posedge clk);
		arst_n <= 1'b1;
		w(1);
		rdchk(ADDR_MODE, MODE_RST, "mode rst2");
		rdchk(ADDR_CAP_LOW, BYTE_RST, "low rst");
		$display("test reset done");
		stop_test;
	end
endmodule
